/* charger_config_registers_bench.sv */
`timescale 1ns/1ps
// ************************************************************
// self-checking bench for the charger configuration registers
// ************************************************************
module charger_config_registers_bench
  import chgcfg_pkg::*;
;
  logic       clk = 1'b0, rst_n = 1'b0, strap = 1'b1, usb = 1'b0, eoc = 1'b0, peak = 1'b0;
  logic       wr, rd, p;
  logic [7:0] addr, wdata, rdata, v, a, d;
  logic [7:0] m [5:7];
  wire  [6:0] thermistor_pin;
  wire  [6:1] tmr;
  wire  [7:0] fs;
  wire        wdr, eq;
  int         miscompares = 0, num_checks = 0, cyc = 0;

  always #12.5 clk = ~clk;

  chgcfg_host h (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

  chgcfg_regs #(.DEGLITCH_CYC(8)) i_dut (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .i_WR(wr), .i_RD(rd), .i_ADDR(addr), .i_WDATA(wdata),
    .i_CHARGE_STRAP(strap), .i_USB_VALID(usb), .i_EOC_DETECT(eoc), .i_PEAK_EVENT(peak), .o_RDATA(rdata),
    .o_RECHARGE_SEL(thermistor_pin[6:5]), .o_DEAD_SEL(thermistor_pin[4:3]), .o_WEAK_SEL(thermistor_pin[2:0]), .o_COMPLETE_TIMER_RUN(tmr[6]),
    .o_EOC_QUALIFIED(eq), .o_CHARGE_TIMER_RUN(tmr[5]), .o_CHARGE_PERIOD_SEL(tmr[4:3]), .o_WATCHDOG_RUN(tmr[2]),
    .o_WATCHDOG_PERIOD_SEL(tmr[1]), .o_WATCHDOG_RESTART(wdr), .o_TEMP_PROFILE_ON(fs[7]), .o_PEAK_SHUTDOWN(fs[6]),
    .o_PEAK_FLAG(fs[5]), .o_BATTERY_MONITOR_ON(fs[4]), .o_THERMISTOR_SOURCE_ON(fs[3]), .o_CONVERTER_ON(fs[2]),
    .o_TRICKLE_ON(fs[1]), .o_CHARGE_ON(fs[0]));

  // stored byte: the spare top bits and the self-clearing restart read back as zero
  function automatic logic [7:0] exp_reg(logic [7:0] ad, logic [7:0] dv);
    return (ad == 8'h05) ? (dv & 8'h7f) : (ad == 8'h06) ? (dv & 8'h7e) : dv;
  endfunction
  // enable outputs seen from the function register and the live conditions
  function automatic logic [7:0] exp_fs(logic [7:0] f, logic u, logic pk);
    return {f[7], pk & ~f[6], pk, u | f[5], u | f[4], f[3] | ~f[1], f[1], f[0] & f[3]};
  endfunction

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // a hang is cut short long after the expected 140 or so cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'hd279e3ba));
    repeat (2) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (2) @(posedge clk);
    // reset contents, the charge enable taken from the strap
    m[5] = 8'h6b;
    m[6] = 8'h78;
    m[7] = 8'h4f;
    for (int r = 5; r < 8; r++) begin
      h.rd(r[7:0], v);
      chk("reset", m[r], v);
    end
    chk("fn_reset", exp_fs(m[7], usb, peak), fs);
    // all ones, all zeros, then random bytes to every register
    for (int i = 0; i < 24; i++) begin
      a = 8'h05 + 8'(i % 3);
      d = (i < 3) ? 8'hff : (i < 6) ? 8'h00 : 8'($urandom);
      h.wr(a, d);
      p = wdr;
      {usb, peak} = 2'($urandom);
      m[a] = exp_reg(a, d);
      h.rd(a, v);
      chk("readback", m[a], v);
      chk("restart", {6'h0, a == 8'h06 && d[0], 1'b0}, {6'h0, p, wdr});
      chk("thresh", m[5], {1'b0, thermistor_pin});
      chk("timer", m[6], {1'b0, tmr, 1'b0});
      chk("func", exp_fs(m[7], usb, peak), fs);
    end
    // unmapped place: writes vanish, reads give zero
    h.wr(8'h08, 8'hff);
    h.rd(8'h08, v);
    chk("unmapped", 8'h00, v);
    // end of charge is still deglitched with the complete timer off
    h.wr(8'h06, 8'h00);
    h.wr(8'h07, 8'h04);
    eoc = 1'b1;
    repeat (3) @(negedge clk);
    chk("eoc_early", 8'h00, {7'h0, eq});
    repeat (10) @(negedge clk);
    chk("eoc_late", 8'h01, {7'h0, eq});
    h.wr(8'h07, 8'h00);
    repeat (3) @(negedge clk);
    chk("eoc_off", 8'h00, {7'h0, eq});
    eoc = 1'b0;
    // second reset in mid-run with the strap low: defaults come back, charging stays off
    strap = 1'b0;
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    m[5] = 8'h6b;
    m[6] = 8'h78;
    m[7] = 8'h4e;
    for (int r = 5; r < 8; r++) begin
      h.rd(r[7:0], v);
      chk("reset_strap_low", m[r], v);
    end
    chk("fn_strap_low", exp_fs(m[7], usb, peak), fs);
    chk("restart_idle", 8'h00, {7'h0, wdr});
    print_verdict();
  end
endmodule

/* chgcfg_decode.sv */
`timescale 1ns/1ps
`include "chgcfg_map.svh"
// ************************************************************
// address decode shared by read and write paths
// ************************************************************
module chgcfg_decode
  import chgcfg_pkg::*;
(
  input  wire logic [7:0] i_addr,
  output logic      [2:0] o_sel
);
  function automatic logic [2:0] chgcfg_sel(input logic [7:0] a);
    chgcfg_sel = {a == `CHGCFG_ADDR_FUNC, a == `CHGCFG_ADDR_TIMER, a == `CHGCFG_ADDR_THRESH};
  endfunction
  // one-hot select, zero for unmapped addresses
  assign o_sel = chgcfg_sel(i_addr);
endmodule

/* chgcfg_host.sv */
`timescale 1ns/1ps
// ************************************************************
// host side of the register port
// ************************************************************
module chgcfg_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr    = 1'b0,
  output logic            o_rd    = 1'b0,
  output logic      [7:0] o_addr  = 8'h00,
  output logic      [7:0] o_wdata = 8'h00
);
  // one byte per strobe, driven at the falling edge and held over the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d; // released lines must not keep the old byte
  endtask
  // read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule

/* chgcfg_map.svh */
`ifndef CHGCFG_MAP_SVH
`define CHGCFG_MAP_SVH
// ************************************************************
// register offsets
// ************************************************************
`define CHGCFG_ADDR_THRESH   8'h05
`define CHGCFG_ADDR_TIMER    8'h06
`define CHGCFG_ADDR_FUNC     8'h07
// ************************************************************
// field positions
// ************************************************************
`define CHGCFG_RCH_LSB       5
`define CHGCFG_DEAD_LSB      3
`define CHGCFG_WEAK_LSB      0
`define CHGCFG_TEND_BIT      6
`define CHGCFG_CTMR_EN_BIT   5
`define CHGCFG_CTMR_PER_LSB  3
`define CHGCFG_WD_EN_BIT     2
`define CHGCFG_WD_PER_BIT    1
`define CHGCFG_WD_RST_BIT    0
`define CHGCFG_TEMP_BIT      7
`define CHGCFG_PKSD_BIT      6
`define CHGCFG_BMON_BIT      5
`define CHGCFG_THR_BIT       4
`define CHGCFG_CONV_BIT      3
`define CHGCFG_EOC_BIT       2
`define CHGCFG_TRK_BIT       1
`define CHGCFG_CHG_BIT       0
// ************************************************************
// reset values and write mask
// ************************************************************
`define CHGCFG_RST_THRESH    8'h6b
`define CHGCFG_RST_TIMER     8'h78
`define CHGCFG_RST_FUNC      8'h4e
`define CHGCFG_WMASK_7BIT    8'h7f
// ************************************************************
// timing
// ************************************************************
`define CHGCFG_CLK_HZ        40000000
`define CHGCFG_DEGLITCH_MS   31
`define CHGCFG_DEGLITCH_CYC  ((`CHGCFG_CLK_HZ / 1000) * `CHGCFG_DEGLITCH_MS)
`endif

/* chgcfg_pkg.sv */
package chgcfg_pkg;
  typedef enum logic [1:0] {CHGCFG_IDLE, CHGCFG_WRITE, CHGCFG_READ} chgcfg_acc_t;
  typedef struct packed {
    logic [7:0]  thresh;
    logic [7:0]  timer;
    logic [7:0]  func;
    logic        wd_restart;
    logic [7:0]  rdata;
    logic        strap_done;
    logic [31:0] dg_cnt;
    logic        eoc_ok;
  } chgcfg_state_t;
endpackage

/* chgcfg_regs.sv */
`timescale 1ns/1ps
`include "chgcfg_map.svh"
// Contract
// - recharge threshold field bits 6:5, codes 80..260 mV, reset 11.
// - dead battery threshold bits 4:3, 2.4/2.5/2.6/3.3 V, reset 01.
// - weak battery threshold bits 2:0, 2.7..3.4 V steps, reset 011.
// - complete timer disabled bypasses timer, 31 ms deglitch still applies; reset one.
// - charge timer runs only while its enable is set; reset one.
// - charge timer period field selects 15/150 to 60/600 minutes, reset 11.
// - watchdog stays disabled while its enable is zero; reset zero.
// - watchdog period bit selects 32 s or 64 s window; reset zero.
// - host writes one to restart; device clears the bit by itself.
// - temperature profile not applied while its enable is zero; reset zero.
// - peak shutdown disable set means only the flag is raised; reset one.
// - battery monitor enable keeps monitor on with low usb input.
// - thermistor source enable keeps source on with low usb input.
// - converter enable zero disables converter; reset one; the code keeps it on while trickle enable is zero.
// - end of charge allowed only while its enable is one; reset one.
// - trickle enable zero disables trickle, enables converter; reset one.
// - charging enabled only when charge and converter enables are one; strap reset.
module chgcfg_regs
  import chgcfg_pkg::*;
#(
  parameter int DEGLITCH_CYC = `CHGCFG_DEGLITCH_CYC
)(
  input  wire logic       I_CLK_SYS,
  input  wire logic       I_RST_N,
  input  wire logic       i_WR,
  input  wire logic       i_RD,
  input  wire logic [7:0] i_ADDR,
  input  wire logic [7:0] i_WDATA,
  input  wire logic       i_CHARGE_STRAP,
  input  wire logic       i_USB_VALID,
  input  wire logic       i_EOC_DETECT,
  input  wire logic       i_PEAK_EVENT,
  output logic      [7:0] o_RDATA,
  output logic      [1:0] o_RECHARGE_SEL,
  output logic      [1:0] o_DEAD_SEL,
  output logic      [2:0] o_WEAK_SEL,
  output logic            o_COMPLETE_TIMER_RUN,
  output logic            o_EOC_QUALIFIED,
  output logic            o_CHARGE_TIMER_RUN,
  output logic      [1:0] o_CHARGE_PERIOD_SEL,
  output logic            o_WATCHDOG_RUN,
  output logic            o_WATCHDOG_PERIOD_SEL,
  output logic            o_WATCHDOG_RESTART,
  output logic            o_TEMP_PROFILE_ON,
  output logic            o_PEAK_SHUTDOWN,
  output logic            o_PEAK_FLAG,
  output logic            o_BATTERY_MONITOR_ON,
  output logic            o_THERMISTOR_SOURCE_ON,
  output logic            o_CONVERTER_ON,
  output logic            o_TRICKLE_ON,
  output logic            o_CHARGE_ON
);
  chgcfg_state_t st;
  chgcfg_state_t next_st;
  logic [2:0]    sel;

  // ************************************************************
  // address decode
  // ************************************************************
  chgcfg_decode u_dec (
    .i_addr (i_ADDR),
    .o_sel  (sel)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.wd_restart = 1'b0; // self clearing after one cycle
    // charge enable is caught from the strap on the first edge after release
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.func[`CHGCFG_CHG_BIT] = i_CHARGE_STRAP;
    end
    if (i_WR) begin
      if (sel[0]) begin
        next_st.thresh = i_WDATA & `CHGCFG_WMASK_7BIT;
      end
      if (sel[1]) begin
        next_st.timer = {1'b0, i_WDATA[6:1], 1'b0};
        next_st.wd_restart = i_WDATA[`CHGCFG_WD_RST_BIT];
      end
      if (sel[2]) begin
        next_st.func = i_WDATA;
      end
    end
    if (i_RD) begin
      // restart bit is write-only and reads zero
      next_st.rdata = ({8{sel[0]}} & st.thresh) | ({8{sel[1]}} & st.timer) | ({8{sel[2]}} & st.func);
    end
    // deglitch end-of-charge when the completion timer is bypassed
    if (!i_EOC_DETECT) begin
      next_st.dg_cnt = '0;
      next_st.eoc_ok = 1'b0;
    end else if (st.dg_cnt >= 32'(DEGLITCH_CYC - 1)) begin
      next_st.eoc_ok = 1'b1;
    end else begin
      next_st.dg_cnt = st.dg_cnt + 32'd1;
    end
  end

  // ************************************************************
  // state register, constants only under reset
  // ************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st <= '{thresh: `CHGCFG_RST_THRESH, timer: `CHGCFG_RST_TIMER, func: `CHGCFG_RST_FUNC,
              wd_restart: 1'b0, rdata: 8'h00, strap_done: 1'b0, dg_cnt: 32'h0, eoc_ok: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // read data and outputs to the analog charger
  // ************************************************************
  assign o_RDATA               = st.rdata;
  assign o_RECHARGE_SEL        = st.thresh[`CHGCFG_RCH_LSB +: 2];
  assign o_DEAD_SEL            = st.thresh[`CHGCFG_DEAD_LSB +: 2];
  assign o_WEAK_SEL            = st.thresh[`CHGCFG_WEAK_LSB +: 3];
  assign o_COMPLETE_TIMER_RUN  = st.timer[`CHGCFG_TEND_BIT];
  // with the timer bypassed, only the deglitched detect may end charging
  assign o_EOC_QUALIFIED       = st.func[`CHGCFG_EOC_BIT] & st.eoc_ok;
  assign o_CHARGE_TIMER_RUN    = st.timer[`CHGCFG_CTMR_EN_BIT];
  assign o_CHARGE_PERIOD_SEL   = st.timer[`CHGCFG_CTMR_PER_LSB +: 2];
  assign o_WATCHDOG_RUN        = st.timer[`CHGCFG_WD_EN_BIT];
  assign o_WATCHDOG_PERIOD_SEL = st.timer[`CHGCFG_WD_PER_BIT];
  assign o_WATCHDOG_RESTART    = st.wd_restart;
  assign o_TEMP_PROFILE_ON     = st.func[`CHGCFG_TEMP_BIT];
  assign o_PEAK_SHUTDOWN       = i_PEAK_EVENT & ~st.func[`CHGCFG_PKSD_BIT];
  assign o_PEAK_FLAG           = i_PEAK_EVENT;
  assign o_BATTERY_MONITOR_ON  = i_USB_VALID | st.func[`CHGCFG_BMON_BIT];
  assign o_THERMISTOR_SOURCE_ON = i_USB_VALID | st.func[`CHGCFG_THR_BIT];
  // trickle off forces the converter on
  assign o_CONVERTER_ON        = st.func[`CHGCFG_CONV_BIT] | ~st.func[`CHGCFG_TRK_BIT];
  assign o_TRICKLE_ON          = st.func[`CHGCFG_TRK_BIT];
  assign o_CHARGE_ON           = st.func[`CHGCFG_CHG_BIT] & st.func[`CHGCFG_CONV_BIT];

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_restart_write;
    i_WR && sel[1] && i_WDATA[0];
  endsequence
  a_restart_pulse: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    s_restart_write |=> o_WATCHDOG_RESTART ##1 (!o_WATCHDOG_RESTART || $past(i_WR && sel[1] && i_WDATA[0])))
    else $error("watchdog restart not self clearing");
  a_top_bit_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_RD && (sel[0] || sel[1]) |=> !o_RDATA[7]) else $error("unused bit read nonzero");
  a_charge_gate: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    o_CHARGE_ON |-> o_CONVERTER_ON && st.func[0]) else $error("charge without converter");
  a_peak_mask: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    st.func[6] |-> !o_PEAK_SHUTDOWN) else $error("shutdown while disabled");
  a_wd_enable_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[1] |=> o_WATCHDOG_RUN == $past(i_WDATA[2])) else $error("watchdog enable not stored");
  a_thresh_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[0] |=> o_RECHARGE_SEL == $past(i_WDATA[6:5]) && o_WEAK_SEL == $past(i_WDATA[2:0]))
    else $error("threshold write lost");
  a_eoc_gate: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !st.func[2] |-> !o_EOC_QUALIFIED) else $error("end of charge while disabled");
  a_eoc_deglitch: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $rose(i_EOC_DETECT) |=> !st.eoc_ok) else $error("deglitch skipped");
  a_trickle_conv: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !o_TRICKLE_ON |-> o_CONVERTER_ON) else $error("converter off without trickle");

  // ************************************************************
  // field routing checks
  // ************************************************************
  a_dead_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[0] |=> o_DEAD_SEL == $past(i_WDATA[4:3])) else $error("dead battery field lost");
  a_tend_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[1] |=> o_COMPLETE_TIMER_RUN == $past(i_WDATA[6])) else $error("complete timer enable lost");
  a_ctmr_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[1] |=> o_CHARGE_TIMER_RUN == $past(i_WDATA[5])) else $error("charge timer enable lost");
  a_period_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[1] |=> o_CHARGE_PERIOD_SEL == $past(i_WDATA[4:3])) else $error("charge timer period lost");
  a_safety_watchdog_period_sel: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[1] |=> o_WATCHDOG_PERIOD_SEL == $past(i_WDATA[1])) else $error("watchdog period lost");
  a_temp_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[2] |=> o_TEMP_PROFILE_ON == $past(i_WDATA[7])) else $error("temperature profile enable lost");
  a_monitor_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    st.func[5] |-> o_BATTERY_MONITOR_ON) else $error("battery monitor dropped");
  a_source_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    st.func[4] |-> o_THERMISTOR_SOURCE_ON) else $error("thermistor source dropped");
  a_conv_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    i_WR && sel[2] && i_WDATA[1] |=> o_CONVERTER_ON == $past(i_WDATA[3])) else $error("converter enable lost");
  // the strap is caught once, unless a host write to the enables lands on the same edge
  a_strap_load: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    $rose(st.strap_done) && !$past(i_WR && sel[2]) |-> st.func[0] == $past(i_CHARGE_STRAP))
    else $error("charge enable not taken from strap");

  // ************************************************************
  // deglitch checks
  // ************************************************************
  // independent count of how long the raw detect has stood, saturating at the deglitch time
  logic [31:0] eoc_hold;
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      eoc_hold <= 32'h0;
    end else if (!i_EOC_DETECT) begin
      eoc_hold <= 32'h0;
    end else if (eoc_hold < 32'(DEGLITCH_CYC)) begin
      eoc_hold <= eoc_hold + 32'd1;
    end
  end
  a_eoc_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    o_EOC_QUALIFIED |-> eoc_hold >= 32'(DEGLITCH_CYC)) else $error("end of charge before deglitch time");
  a_eoc_release: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    st.func[2] && eoc_hold >= 32'(DEGLITCH_CYC) |-> o_EOC_QUALIFIED) else $error("end of charge withheld");
endmodule
